// ---- core/sids_pkg.sv ----
// Constants for the split interrupt descriptor status block.
// Assumes a 32-bit AXI4-Lite register bus and one controller clock.
package sids_pkg;
	// Geometry
	localparam int UF_COUNT = 8;
	localparam int UF_W = 3;
	localparam int BYTE_W = 8;
	localparam int RES_W = 3;
	localparam int FRAME_W = 5;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_FRAME = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_SSMASK = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_CSMASK = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_BYTES_LO = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_BYTES_HI = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 6'h28;
	// Control fields
	localparam int CTRL_DIR_IN = 0;
	localparam int CTRL_ENABLE = 1;
	// Result field bits
	localparam int RES_XERR = 0;
	localparam int RES_BABBLE = 1;
	localparam int RES_UNDERRUN = 2;
	// Flag register bits
	localparam int FLG_XERR = 0;
	localparam int FLG_BABBLE = 1;
	localparam int FLG_HALT = 2;
	// Interrupt event bits
	localparam int IRQ_W = 4;
	localparam int EV_DONE = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_HALT = 2;
	localparam int EV_CS_EMPTY = 3;
	// Start splits of IN transfers only in microframes 0 to 3
	localparam logic [UF_COUNT-1:0] IN_SS_ALLOWED = 8'h0f;
	// Reset values and bus answers
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : sids_pkg

// ---- core/sids_sched.sv ----
// Microframe scheduler: issues start and complete splits.
// Assumes tick and microframe number come from the frame timer on clk.
`timescale 1ns/1ps
`default_nettype none
module sids_sched (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic uframeTick,
	input wire logic [sids_pkg::UF_W-1:0] uframeNum,
	input wire logic frameMatch,
	input wire logic enable,
	input wire logic dirIn,
	input wire logic [sids_pkg::UF_COUNT-1:0] ssMask,
	input wire logic [sids_pkg::UF_COUNT-1:0] csMask,
	output logic ssIssue_r,
	output logic csIssue_r,
	output logic [sids_pkg::UF_W-1:0] issueUf_r
);
	import sids_pkg::*;

	logic [UF_COUNT-1:0] ssEff;
	logic ssHit;
	logic csHit;

	// IN start splits beyond microframe 3 are never placed
	assign ssEff = dirIn ? (ssMask & IN_SS_ALLOWED) : ssMask;
	// Start split wherever its mask bit selects this microframe
	assign ssHit = enable && frameMatch && ssEff[uframeNum];
	// Complete split per mask bit, IN only, start split has priority
	assign csHit = enable && frameMatch && dirIn && csMask[uframeNum] && !ssHit;

	// One-cycle issue strobes, registered one cycle after the microframe tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ssIssue_r <= 1'b0;
			csIssue_r <= 1'b0;
			issueUf_r <= '0;
		end else begin
			ssIssue_r <= uframeTick && ssHit;
			csIssue_r <= uframeTick && csHit;
			if (uframeTick) begin
				issueUf_r <= uframeNum;
			end
		end
	end
endmodule : sids_sched
`default_nettype wire

// ---- core/sids_result.sv ----
// Per-microframe result recorder with the sticky halt summary flag.
// Assumes one completion pulse per transaction, on clk.
`timescale 1ns/1ps
`default_nettype none
module sids_result (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic done,
	input wire logic [sids_pkg::UF_W-1:0] doneUf,
	input wire logic dirIn,
	input wire logic xerr,
	input wire logic babble,
	input wire logic underrun,
	input wire logic halt,
	output logic [sids_pkg::UF_COUNT*sids_pkg::RES_W-1:0] results_r,
	output logic halt_r
);
	import sids_pkg::*;

	logic [RES_W-1:0] newRes;

	// Bit 0 both ways, babble on IN only, underrun on OUT only
	assign newRes[RES_XERR] = xerr;
	assign newRes[RES_BABBLE] = babble && dirIn;
	assign newRes[RES_UNDERRUN] = underrun && !dirIn;

	// Field of microframe n sits at bits 3n+2..3n; completion beats clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			results_r <= '0;
		end else begin
			if (clear) begin
				results_r <= '0;
			end
			if (done) begin
				results_r[doneUf*RES_W +: RES_W] <= newRes;
			end
		end
	end

	// Sticky halt, set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halt_r <= 1'b0;
		end else begin
			halt_r <= (done && halt) || (halt_r && !clear);
		end
	end
endmodule : sids_result
`default_nettype wire

// ---- core/sids_top.sv ----
// Split interrupt descriptor status block: registers, capture, interrupt.
// Assumes an AXI4-Lite master on clk and a split engine on the same clock.
//
// Summary of operation
// - Capture IN bytes when start bit, frame match
// - New capture overwrites old byte count
// - Software sets complete mask, hardware clears processed
// - Complete split per mask bit, IN only
// - Start mask 01, complete 04: uframes 0, 2
// - Eight packed 3-bit results, uframe 0 lowest
// - Result bit 0 marks transaction error
// - Result bit 1 marks babble, IN only
// - Result bit 2 marks underrun, OUT only
// - Start mask bits select start split microframes, 0 to 3 only for IN
// - Babble, error flags OR result bits
// - Halt flag set on any halted result
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sids_top (
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [sids_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [sids_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sids_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [sids_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Frame timer
	input wire logic uframeTick,
	input wire logic [sids_pkg::UF_W-1:0] uframeNum,
	input wire logic [sids_pkg::FRAME_W-1:0] frameNum,
	// Split engine completion
	input wire logic xferDone,
	input wire logic xferIsCs,
	input wire logic [sids_pkg::UF_W-1:0] xferUf,
	input wire logic [sids_pkg::BYTE_W-1:0] xferBytes,
	input wire logic xferXerr,
	input wire logic xferBabble,
	input wire logic xferUnderrun,
	input wire logic xferHalt,
	// Split issue and interrupt
	output logic ssIssue,
	output logic csIssue,
	output logic [sids_pkg::UF_W-1:0] issueUf,
	output logic irq
);
	import sids_pkg::*;

	// Byte-enable merge of a register write
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Bus handshake state
	logic awFree_r;
	logic wFree_r;
	logic [ADDR_W-1:0] awAddr_r;
	logic [DATA_W-1:0] wData_r;
	logic [3:0] wStrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	// Software registers
	logic [DATA_W-1:0] ctrl_r;
	logic [FRAME_W-1:0] frame_r;
	logic [UF_COUNT-1:0] ssMask_r;
	logic [UF_COUNT-1:0] csMask_r;
	logic [IRQ_W-1:0] irqStat_r;
	logic [IRQ_W-1:0] irqEn_r;
	logic irq_r;
	logic [BYTE_W-1:0] bytes_r [UF_COUNT];
	// Sub-module outputs
	logic [UF_COUNT*RES_W-1:0] results;
	logic haltFlag;
	logic ssIssueS;
	logic csIssueS;
	logic [UF_W-1:0] issueUfS;
	// Write decode
	logic doWrite;
	logic [DATA_W-1:0] wMerged;
	logic wrCtrl;
	logic wrFrame;
	logic wrSs;
	logic wrCs;
	logic wrResult;
	logic wrIrqClr;
	logic wrIrqEn;
	logic wrMapped;
	assign doWrite = !awFree_r && !wFree_r && !bvalid_r;
	assign wMerged = merge(RST_ZERO, wData_r, wStrb_r);
	assign wrCtrl = doWrite && awAddr_r == OFS_CTRL;
	assign wrFrame = doWrite && awAddr_r == OFS_FRAME;
	assign wrSs = doWrite && awAddr_r == OFS_SSMASK;
	assign wrCs = doWrite && awAddr_r == OFS_CSMASK;
	assign wrResult = doWrite && awAddr_r == OFS_RESULT;
	assign wrIrqClr = doWrite && awAddr_r == OFS_IRQ_CLR;
	assign wrIrqEn = doWrite && awAddr_r == OFS_IRQ_EN;
	assign wrMapped = wrCtrl || wrFrame || wrSs || wrCs || wrResult || wrIrqClr || wrIrqEn;
	// Control decode
	logic dirIn;
	logic enable;
	logic frameMatch;
	logic capture;
	logic csDone;
	logic [UF_COUNT-1:0] csClr;
	logic [UF_COUNT-1:0] csMask_nxt;
	logic anyXerr;
	logic anyBabble;
	logic [IRQ_W-1:0] events;
	assign dirIn = ctrl_r[CTRL_DIR_IN];
	assign enable = ctrl_r[CTRL_ENABLE];
	assign frameMatch = frameNum == frame_r;
	// Byte count kept only with start bit set and frame matching
	assign capture = xferDone && dirIn && ssMask_r[xferUf] && frameMatch;
	assign csDone = xferDone && xferIsCs;
	assign csClr = csDone ? (UF_COUNT'(1) << xferUf) : '0;
	// Hardware clears processed bits, software sets win
	assign csMask_nxt = wrCs ? (csMask_r & ~csClr) | wMerged[UF_COUNT-1:0] : csMask_r & ~csClr;

	// Summary flags from all eight result fields
	always_comb begin
		anyXerr = 1'b0;
		anyBabble = 1'b0;
		for (int i = 0; i < UF_COUNT; i++) begin
			anyXerr = anyXerr | results[i*RES_W + RES_XERR];
			anyBabble = anyBabble | results[i*RES_W + RES_BABBLE];
		end
	end

	// Interrupt events
	assign events[EV_DONE] = xferDone;
	assign events[EV_ERROR] = xferDone && (xferXerr || (xferBabble && dirIn) || (xferUnderrun && !dirIn));
	assign events[EV_HALT] = xferDone && xferHalt;
	assign events[EV_CS_EMPTY] = csDone && csMask_r != '0 && (csMask_r & ~csClr) == '0;
	// Read decode
	logic [DATA_W-1:0] rdMux;
	logic rdMapped;
	always_comb begin
		rdMux = RST_ZERO;
		rdMapped = 1'b1;
		case (s_axi_araddr)
			OFS_CTRL: rdMux = ctrl_r;
			OFS_FRAME: rdMux = DATA_W'(frame_r);
			OFS_SSMASK: rdMux = DATA_W'(ssMask_r);
			OFS_CSMASK: rdMux = DATA_W'(csMask_r);
			OFS_RESULT: rdMux = DATA_W'(results);
			OFS_FLAGS: begin
				rdMux[FLG_XERR] = anyXerr;
				rdMux[FLG_BABBLE] = anyBabble;
				rdMux[FLG_HALT] = haltFlag;
			end
			OFS_BYTES_LO: rdMux = {bytes_r[3], bytes_r[2], bytes_r[1], bytes_r[0]};
			OFS_BYTES_HI: rdMux = {bytes_r[7], bytes_r[6], bytes_r[5], bytes_r[4]};
			OFS_IRQ_STAT: rdMux = DATA_W'(irqStat_r);
			OFS_IRQ_CLR: rdMux = RST_ZERO;
			OFS_IRQ_EN: rdMux = DATA_W'(irqEn_r);
			default: rdMapped = 1'b0;
		endcase
	end

	// Write address and data channels, taken in either order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awFree_r <= 1'b1; // Free flags are the ready outputs
			wFree_r <= 1'b1;
			awAddr_r <= '0;
			wData_r <= RST_ZERO;
			wStrb_r <= '0;
		end else begin
			if (s_axi_awvalid && awFree_r) begin
				awFree_r <= 1'b0;
				awAddr_r <= s_axi_awaddr;
			end else if (doWrite) begin
				awFree_r <= 1'b1;
			end
			if (s_axi_wvalid && wFree_r) begin
				wFree_r <= 1'b0;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wFree_r <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_r <= 1'b1;
			bresp_r <= wrMapped ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read channel, one outstanding read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= RST_ZERO;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= !rvalid_r && !arready_r && s_axi_arvalid;
			if (arready_r) begin
				rvalid_r <= 1'b1;
				rdata_r <= rdMux;
				rresp_r <= rdMapped ? RESP_OKAY : RESP_DECERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Control, frame and mask registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= RST_ZERO;
			frame_r <= '0;
			ssMask_r <= '0;
			csMask_r <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_r <= merge(ctrl_r, wData_r, wStrb_r);
			end
			if (wrFrame) begin
				frame_r <= wMerged[FRAME_W-1:0];
			end
			if (wrSs) begin
				ssMask_r <= wMerged[UF_COUNT-1:0];
			end
			csMask_r <= csMask_nxt;
		end
	end

	// Received byte counts, each capture replaces the old value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < UF_COUNT; i++) begin
				bytes_r[i] <= '0;
			end
		end else if (capture) begin
			bytes_r[xferUf] <= xferBytes;
		end
	end

	// Sticky interrupt status, set beats clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStat_r <= '0;
			irqEn_r <= '0;
			irq_r <= 1'b0;
		end else begin
			irqStat_r <= events | (irqStat_r & ~(wrIrqClr ? wMerged[IRQ_W-1:0] : '0));
			if (wrIrqEn) begin
				irqEn_r <= wMerged[IRQ_W-1:0];
			end
			irq_r <= (irqStat_r & irqEn_r) != '0;
		end
	end

	// Split scheduling
	sids_sched u_sched (
		.clk(clk),
		.rst_n(rst_n),
		.uframeTick(uframeTick),
		.uframeNum(uframeNum),
		.frameMatch(frameMatch),
		.enable(enable),
		.dirIn(dirIn),
		.ssMask(ssMask_r),
		.csMask(csMask_r),
		.ssIssue_r(ssIssueS),
		.csIssue_r(csIssueS),
		.issueUf_r(issueUfS)
	);

	// Result fields and halt flag
	sids_result u_result (
		.clk(clk),
		.rst_n(rst_n),
		.clear(wrResult),
		.done(xferDone),
		.doneUf(xferUf),
		.dirIn(dirIn),
		.xerr(xferXerr),
		.babble(xferBabble),
		.underrun(xferUnderrun),
		.halt(xferHalt),
		.results_r(results),
		.halt_r(haltFlag)
	);

	// Outputs, all from flip-flops
	assign s_axi_awready = awFree_r;
	assign s_axi_wready = wFree_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign ssIssue = ssIssueS;
	assign csIssue = csIssueS;
	assign issueUf = issueUfS;
	assign irq = irq_r;
endmodule : sids_top
`default_nettype wire

// ---- tb/sids_top_checker.sv ----
// Checker: port timing of the split descriptor block.
// Assumes binding to sids_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sids_top_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [sids_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic uframeTick,
	input wire logic [sids_pkg::UF_W-1:0] uframeNum,
	input wire logic xferDone,
	input wire logic ssIssue,
	input wire logic csIssue,
	input wire logic [sids_pkg::UF_W-1:0] issueUf,
	input wire logic irq
);
	import sids_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Split strobes follow a tick, one kind, one cycle
	ss_after_tick_a: assert property (ssIssue |-> $past(uframeTick))
		else $error("start split without tick");
	cs_after_tick_a: assert property (csIssue |-> $past(uframeTick))
		else $error("complete split without tick");
	issue_uf_a: assert property ($past(uframeTick) |-> issueUf == $past(uframeNum))
		else $error("issue microframe wrong");
	one_kind_a: assert property (!(ssIssue && csIssue))
		else $error("both splits at once");
	strobe_pulse_a: assert property ((ssIssue || csIssue) |=> !ssIssue && !csIssue)
		else $error("issue strobe too long");
	// Bus answers hold until taken
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Interrupt rises only after an event or a write
	irq_cause_a: assert property ($rose(irq) |-> $past(xferDone, 2) || $past(xferDone, 3)
		|| $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("interrupt without cause");
endmodule : sids_top_checker
bind sids_top sids_top_checker chk (.*);
`default_nettype wire

// ---- tb/sids_partner.sv ----
// Partner model: split engine answering each issued split.
// Assumes strobes on clk; latency and results set by the bench.
`timescale 1ns/1ps
`default_nettype none
module sids_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ssIssue,
	input wire logic csIssue,
	input wire logic [2:0] issueUf,
	input wire logic [3:0] partLat,
	input wire logic [7:0] partBytes,
	input wire logic [3:0] partErr,
	output logic xferDone,
	output logic xferIsCs,
	output logic [2:0] xferUf,
	output logic [7:0] xferBytes,
	output logic xferHalt,
	output logic xferUnderrun,
	output logic xferBabble,
	output logic xferXerr
);
	import sids_pkg::*;
	logic pend_r, cs_r;
	logic [2:0] uf_r;
	logic [3:0] cnt_r;
	logic [15:0] qual_r;
	// Qualifiers toggle except with the done pulse
	assign {xferIsCs, xferUf, xferBytes, xferHalt, xferUnderrun, xferBabble, xferXerr} = qual_r;
	// Answer partLat+1 cycles after taking a strobe, with one done pulse
	always_ff @(posedge clk) begin
		xferDone <= 1'b0;
		qual_r <= ~qual_r;
		if (!rst_n) begin
			pend_r <= 1'b0;
			qual_r <= 16'h0000;
		end else if (ssIssue || csIssue) begin
			pend_r <= 1'b1;
			cnt_r <= partLat;
			cs_r <= csIssue;
			uf_r <= issueUf;
		end else if (pend_r && cnt_r == 4'h0) begin
			pend_r <= 1'b0;
			xferDone <= 1'b1;
			qual_r <= {cs_r, uf_r, partBytes, partErr};
		end else if (pend_r) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule : sids_partner
`default_nettype wire

// ---- tb/tb_sids_top.sv ----
// Testbench: registers, split issue and results of sids_top.
// Assumes the partner model answers every issued split.
`timescale 1ns/1ps
`default_nettype none
module tb_sids_top;
	import sids_pkg::*;
	logic clk, rst_n, uframeTick, xferDone, xferIsCs, xferXerr, xferBabble, xferUnderrun, xferHalt;
	logic ssIssue, csIssue, irq;
	logic [2:0] uframeNum, xferUf, issueUf;
	logic [4:0] frameNum;
	logic [7:0] xferBytes, partBytes;
	logic [3:0] partLat, partErr, s_axi_wstrb;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int fails = 0;
	int checks = 0;
	sids_top uut (.*);
	sids_partner part (.*);
	// Comparison and verdict
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	// Bus cycles: payload held until its ready is sampled
	task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] e = RESP_OKAY,
		input logic [3:0] st = 4'hf);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string s);
		rd(a);
		cmp(s, e, d);
		cmp("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : rchk
	// One microframe tick, then the issue strobes one cycle later
	task automatic tick(input logic [2:0] u, input logic [1:0] e);
		@(posedge clk);
		uframeTick <= 1'b1;
		uframeNum <= u;
		@(posedge clk);
		uframeTick <= 1'b0;
		#1 cmp("issue", {27'h0, e, u}, {27'h0, ssIssue, csIssue, issueUf});
		repeat (12) @(posedge clk);
	endtask : tick
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog
	initial begin
		#300000;
		fails++;
		conclude();
	end
	// Main sequence
	initial begin
		{rst_n, uframeTick, uframeNum, frameNum, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{partLat, partErr} = '0;
		partBytes = 8'h11;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_CSMASK, RST_ZERO, "csmask");
		rchk(OFS_RESULT, RST_ZERO, "result");
		rchk(OFS_FLAGS, RST_ZERO, "flags");
		rd(6'h2c);
		cmp("unmapped", RST_ZERO, d);
		cmp("rresp", {30'h0, RESP_DECERR}, {30'h0, r});
		wr(6'h30, 32'h1, RESP_DECERR);
		frameNum <= 5'h05;
		wr(OFS_FRAME, 32'h5);
		wr(OFS_CTRL, 32'h3);
		wr(OFS_CTRL, 32'h0, RESP_OKAY, 4'h2);
		rchk(OFS_CTRL, 32'h3, "ctrl");
		wr(OFS_SSMASK, 32'h01);
		wr(OFS_CSMASK, 32'h04);
		wr(OFS_IRQ_EN, 32'hf);
		tick(3'h0, 2'b10);
		rchk(OFS_BYTES_LO, 32'h11, "bytes");
		tick(3'h1, 2'b00);
		partBytes <= 8'h22;
		tick(3'h2, 2'b01);
		rchk(OFS_CSMASK, RST_ZERO, "csmask");
		rchk(OFS_IRQ_STAT, 32'h9, "irqstat");
		cmp("irq", 32'h1, {31'h0, irq});
		rchk(OFS_BYTES_LO, 32'h11, "bytes");
		tick(3'h2, 2'b00);
		partLat <= 4'h7;
		partBytes <= 8'h33;
		partErr <= 4'h7;
		tick(3'h0, 2'b10);
		rchk(OFS_BYTES_LO, 32'h33, "bytes");
		rchk(OFS_RESULT, 32'h3, "result");
		rchk(OFS_FLAGS, 32'h3, "flags");
		frameNum <= 5'h06;
		tick(3'h0, 2'b00);
		frameNum <= 5'h05;
		wr(OFS_SSMASK, 32'h11);
		tick(3'h4, 2'b00);
		wr(OFS_RESULT, 32'h0);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_SSMASK, 32'h80);
		wr(OFS_CSMASK, 32'h04);
		partErr <= 4'hf;
		tick(3'h2, 2'b00);
		tick(3'h7, 2'b10);
		rchk(OFS_RESULT, 32'h00a00000, "result");
		rchk(OFS_FLAGS, 32'h5, "flags");
		rchk(OFS_BYTES_HI, RST_ZERO, "bytes");
		wr(OFS_IRQ_EN, 32'h0);
		@(posedge clk);
		#1 cmp("irq", 32'h0, {31'h0, irq});
		rchk(OFS_IRQ_STAT, 32'hf, "irqstat");
		wr(OFS_IRQ_CLR, 32'hf);
		rchk(OFS_IRQ_STAT, RST_ZERO, "irqstat");
		conclude();
	end
endmodule : tb_sids_top
`default_nettype wire
